/* rtl/axis_motion_pkg.sv */
// Notes on behaviour
// - In-position result is zero at or within deadband of target, else the distance.
// - Kill stop disables the motor control output at once, with no deceleration ramp.
// - A killed axis asserts its inhibit output so the amplifier is disabled.
// - Kill flushes the triggered command buffer, released entries included.
// - On kill, stepper step and clockwise/counter-clockwise pulses stop at once.
// - Servo acceleration is 1 to 16,777,215, power-up default 524,288.
// - Stepper acceleration is 1 to 5,242,879, power-up default 3.
// - Out-of-range loads clamp to the nearer limit and complete without error.
// - The same acceleration value ramps speed both up and down.
// - An acceleration load while the axis moves is discarded.
// - Stepper boost factor is 1 to 10, power-up default 1.
// - Boost multiplier falls with speed, reaching one at the target rate.
// - Breakpoint repeat period is 0 to 16,777,215; zero is default and disables it.
// - With nonzero period, absolute breakpoint is period start plus loaded value.
// - Relative breakpoints ignore the repeat period.
// - A loaded period persists until reloaded or reset; zero disables it.
// - For negative positions the period start is its more negative boundary.
package axis_motion_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_ACCEL = 6'h04;
    localparam logic [5:0] OFF_FACTOR = 6'h08;
    localparam logic [5:0] OFF_PERIOD = 6'h0C;
    localparam logic [5:0] OFF_VMAX = 6'h10;
    localparam logic [5:0] OFF_MOVE_TGT = 6'h14;
    localparam logic [5:0] OFF_POS_TGT = 6'h18;
    localparam logic [5:0] OFF_DEADBAND = 6'h1C;
    localparam logic [5:0] OFF_BRK_VAL = 6'h20;
    localparam logic [5:0] OFF_TRIG = 6'h24;
    localparam logic [5:0] OFF_POSITION = 6'h28;
    localparam logic [5:0] OFF_INPOS = 6'h2C;
    localparam logic [5:0] OFF_BRK_POS = 6'h30;
    localparam logic [5:0] OFF_STATUS = 6'h34;
    localparam int CTRL_START = 0;
    localparam int CTRL_KILL = 1;
    localparam int CTRL_ARM_ABS = 2;
    localparam int CTRL_ARM_REL = 3;
    localparam int STS_MOVING = 0;
    localparam int STS_KILLED = 1;
    localparam int STS_ARMED = 2;
    localparam int STS_HIT = 3;
    localparam int STS_TFULL = 4;
    localparam logic [31:0] ACC_MIN = 32'h0000_0001;
    localparam logic [31:0] SERVO_ACC_MAX = 32'h00FF_FFFF;
    localparam logic [31:0] SERVO_ACC_DEF = 32'h0008_0000;
    localparam logic [31:0] STEP_ACC_MAX = 32'h004F_FFFF;
    localparam logic [31:0] STEP_ACC_DEF = 32'h0000_0003;
    localparam logic [31:0] FACT_MIN = 32'h0000_0001;
    localparam logic [31:0] FACT_MAX = 32'h0000_000A;
    localparam logic [31:0] FACT_DEF = 32'h0000_0001;
    localparam logic [31:0] PER_MIN = 32'h0000_0000;
    localparam logic [31:0] PER_MAX = 32'h00FF_FFFF;
    localparam logic [31:0] PER_DEF = 32'h0000_0000;
    localparam logic [31:0] VMAX_DEF = 32'h0001_0000;
    localparam logic [31:0] VEL_MIN = 32'h0000_1000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_NS = 8;
    localparam int SAMPLE_US = 341;
    localparam int SAMPLE_CYC = SAMPLE_US * 1000 / CLK_NS;
    typedef enum logic [2:0] {M_IDLE, M_RAMP, M_CRUISE, M_BRAKE, M_KILLED} mstate_t;
endpackage : axis_motion_pkg

/* rtl/shape_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface shape_if;
    logic clk;
    logic rst_n;
    logic servo;
    logic [23:0] accel;
    logic [3:0] factor;
    logic [31:0] vel;
    logic [31:0] vmax;
    logic [31:0] eff;
    modport src(output clk, rst_n, servo, accel, factor, vel, vmax, input eff);
    modport calc(input clk, rst_n, servo, accel, factor, vel, vmax, output eff);
endinterface : shape_if
`default_nettype wire

/* rtl/accel_shaper.sv */
`timescale 1ns/100ps
`default_nettype none
module accel_shaper (
    shape_if.calc sh
);
    logic [31:0] span;
    logic [63:0] extra;

    // The boost tapers linearly from the full factor at rest to one at the target rate.
    always_comb begin
        span = (sh.vel < sh.vmax) ? sh.vmax - sh.vel : 32'h0000_0000;
        extra = 64'h0;
        if (!sh.servo && sh.factor > 4'h1 && sh.vmax != 32'h0) begin
            extra = ({40'h0, sh.accel} * {60'h0, sh.factor - 4'h1} * {32'h0, span})
                / {32'h0, sh.vmax};
        end
        sh.eff = {8'h00, sh.accel} + extra[31:0];
    end

    eff_bounds_a: assert property (@(posedge sh.clk) disable iff (!sh.rst_n)
        sh.eff >= {8'h00, sh.accel}
        && sh.eff <= {8'h00, sh.accel} * {28'h0, (sh.factor == 4'h0) ? 4'h1 : sh.factor})
        else $error("boosted acceleration outside accel..accel*factor");
    eff_top_a: assert property (@(posedge sh.clk) disable iff (!sh.rst_n)
        (sh.vel >= sh.vmax) |-> sh.eff == {8'h00, sh.accel})
        else $error("boost not one at target rate");
endmodule : accel_shaper
`default_nettype wire

/* rtl/axis_motion_param_unit.sv */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module axis_motion_param_unit #(
    parameter bit IS_SERVO = 1'b1,
    parameter int SAMPLE_CYC = axis_motion_pkg::SAMPLE_CYC,
    parameter int TRIG_DEPTH = 4
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [5:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [5:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic TRIG_IN,
    output logic MOTOR_EN,
    output logic [15:0] MOTOR_CMD,
    output logic INHIBIT_OUT,
    output logic STEP_OUT,
    output logic DIR_OUT,
    output logic CW_OUT,
    output logic CCW_OUT,
    output logic BREAK_OUT
);
    localparam int TW = $clog2(SAMPLE_CYC + 1);
    localparam int CW = $clog2(TRIG_DEPTH + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(SAMPLE_CYC - 1);
    localparam logic [CW-1:0] TFULL = CW'(TRIG_DEPTH);
    localparam logic [31:0] ACC_MAX = IS_SERVO ? axis_motion_pkg::SERVO_ACC_MAX
                                               : axis_motion_pkg::STEP_ACC_MAX;
    localparam logic [31:0] ACC_DEF = IS_SERVO ? axis_motion_pkg::SERVO_ACC_DEF
                                               : axis_motion_pkg::STEP_ACC_DEF;

    typedef struct packed {
        axis_motion_pkg::mstate_t st;
        logic aw_h;
        logic w_h;
        logic [5:0] aw_a;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [1:0] rr;
        logic [31:0] rd;
        logic [23:0] accel;
        logic [3:0] fact;
        logic [23:0] per;
        logic [31:0] vmax;
        logic [31:0] mtgt;
        logic [31:0] ptgt;
        logic [31:0] dband;
        logic [31:0] bval;
        logic [31:0] bpos;
        logic [31:0] pres;
        logic [31:0] pos;
        logic [15:0] frac;
        logic [31:0] vel;
        logic [31:0] rdist;
        logic dir;
        logic bp_arm;
        logic bp_hit;
        logic [TRIG_DEPTH-1:0][31:0] tb;
        logic [CW-1:0] tcnt;
        logic trel;
        logic [TW-1:0] tick;
        logic step;
        logic cw;
        logic ccw;
        logic brk;
        logic [15:0] mcmd;
    } state_t;

    state_t s, n;
    shape_if sh();
    logic do_wr;
    logic [31:0] wmask;
    logic wr_kill;
    logic [31:0] div;
    logic signed [31:0] quo;
    logic signed [31:0] rem;
    logic signed [31:0] per_start;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        return a[5:2] == off[5:2];
    endfunction : hit

    function automatic logic is_moving(input axis_motion_pkg::mstate_t st);
        return st inside {axis_motion_pkg::M_RAMP, axis_motion_pkg::M_CRUISE,
                          axis_motion_pkg::M_BRAKE};
    endfunction : is_moving

    // Clamp rather than reject, so every load completes with an OKAY answer.
    function automatic logic [31:0] sat(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : sat

    function automatic logic [31:0] absd(input logic [31:0] a, input logic [31:0] b);
        logic signed [32:0] d;
        d = $signed({a[31], a}) - $signed({b[31], b});
        return d[32] ? 32'(-d) : d[31:0];
    endfunction : absd

    function automatic logic [32:0] rd_of(input logic [5:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        if (hit(a, axis_motion_pkg::OFF_ACCEL)) r[31:0] = {8'h00, s.accel};
        else if (hit(a, axis_motion_pkg::OFF_FACTOR)) r[31:0] = {28'h0, s.fact};
        else if (hit(a, axis_motion_pkg::OFF_PERIOD)) r[31:0] = {8'h00, s.per};
        else if (hit(a, axis_motion_pkg::OFF_VMAX)) r[31:0] = s.vmax;
        else if (hit(a, axis_motion_pkg::OFF_MOVE_TGT)) r[31:0] = s.mtgt;
        else if (hit(a, axis_motion_pkg::OFF_POS_TGT)) r[31:0] = s.ptgt;
        else if (hit(a, axis_motion_pkg::OFF_DEADBAND)) r[31:0] = s.dband;
        else if (hit(a, axis_motion_pkg::OFF_BRK_VAL)) r[31:0] = s.bval;
        else if (hit(a, axis_motion_pkg::OFF_TRIG)) r[31:0] = 32'(s.tcnt);
        else if (hit(a, axis_motion_pkg::OFF_POSITION)) r[31:0] = s.pos;
        else if (hit(a, axis_motion_pkg::OFF_INPOS)) r[31:0] = s.pres;
        else if (hit(a, axis_motion_pkg::OFF_BRK_POS)) r[31:0] = s.bpos;
        else if (hit(a, axis_motion_pkg::OFF_STATUS)) begin
            r[axis_motion_pkg::STS_MOVING] = is_moving(s.st);
            r[axis_motion_pkg::STS_KILLED] = s.st == axis_motion_pkg::M_KILLED;
            r[axis_motion_pkg::STS_ARMED] = s.bp_arm;
            r[axis_motion_pkg::STS_HIT] = s.bp_hit;
            r[axis_motion_pkg::STS_TFULL] = s.tcnt == TFULL;
        end
        else if (!hit(a, axis_motion_pkg::OFF_CTRL)) r[32] = 1'b0;
        return r;
    endfunction : rd_of

    assign sh.clk = REF_CLK;
    assign sh.rst_n = RSTN;
    assign sh.servo = IS_SERVO;
    assign sh.accel = s.accel;
    assign sh.factor = s.fact;
    assign sh.vel = s.vel;
    assign sh.vmax = s.vmax;

    accel_shaper u_shaper (
        .sh(sh.calc)
    );

    assign do_wr = s.aw_h && s.w_h && !s.bv;
    assign wmask = {{8{s.ws[3]}}, {8{s.ws[2]}}, {8{s.ws[1]}}, {8{s.ws[0]}}};
    assign wr_kill = do_wr && hit(s.aw_a, axis_motion_pkg::OFF_CTRL) && s.ws[0]
        && s.wd[axis_motion_pkg::CTRL_KILL];

    // Floor division keeps the period start on the more negative boundary below zero.
    assign div = (s.per == 24'h0) ? 32'h0000_0001 : {8'h00, s.per};
    assign quo = $signed(s.pos) / $signed(div);
    assign rem = $signed(s.pos) % $signed(div);
    assign per_start = ((s.pos[31] && rem != 0) ? quo - 32'sd1 : quo) * $signed(div);

    assign AWREADY = !s.aw_h && !s.bv;
    assign WREADY = !s.w_h && !s.bv;
    assign BVALID = s.bv;
    assign BRESP = s.br;
    assign ARREADY = !s.rv;
    assign RVALID = s.rv;
    assign RDATA = s.rd;
    assign RRESP = s.rr;
    assign MOTOR_EN = IS_SERVO && s.st != axis_motion_pkg::M_KILLED;
    assign INHIBIT_OUT = s.st == axis_motion_pkg::M_KILLED;
    assign MOTOR_CMD = s.mcmd;
    assign STEP_OUT = s.step;
    assign CW_OUT = s.cw;
    assign CCW_OUT = s.ccw;
    assign DIR_OUT = s.dir;
    assign BREAK_OUT = s.brk;

    always_comb begin
        logic [32:0] rdv;
        logic [31:0] wv;
        logic go;
        logic [31:0] go_tgt;
        logic tk;
        logic signed [31:0] left;
        logic [47:0] np;
        logic [31:0] v;
        rdv = 33'h0;
        wv = 32'h0;
        go = 1'b0;
        go_tgt = s.mtgt;
        tk = s.tick == TICK_LAST;
        left = 32'sd0;
        np = {s.pos, s.frac};
        v = s.vel;
        n = s;
        n.step = 1'b0;
        n.cw = 1'b0;
        n.ccw = 1'b0;
        n.brk = 1'b0;
        n.tick = tk ? '0 : s.tick + 1'b1;
        if (AWVALID && AWREADY) begin
            n.aw_h = 1'b1;
            n.aw_a = AWADDR;
        end
        if (WVALID && WREADY) begin
            n.w_h = 1'b1;
            n.wd = WDATA;
            n.ws = WSTRB;
        end
        if (BREADY && s.bv) n.bv = 1'b0;
        if (RREADY && s.rv) n.rv = 1'b0;
        if (ARVALID && ARREADY) begin
            rdv = rd_of(ARADDR);
            n.rv = 1'b1;
            n.rd = rdv[31:0];
            n.rr = rdv[32] ? axis_motion_pkg::RESP_OKAY : axis_motion_pkg::RESP_SLVERR;
        end
        if (do_wr) begin
            rdv = rd_of(s.aw_a);
            wv = (rdv[31:0] & ~wmask) | (s.wd & wmask);
            n.aw_h = 1'b0;
            n.w_h = 1'b0;
            n.bv = 1'b1;
            n.br = rdv[32] ? axis_motion_pkg::RESP_OKAY : axis_motion_pkg::RESP_SLVERR;
            if (hit(s.aw_a, axis_motion_pkg::OFF_CTRL)) begin
                go = wv[axis_motion_pkg::CTRL_START] && (s.st == axis_motion_pkg::M_IDLE
                    || s.st == axis_motion_pkg::M_KILLED);
                if (wv[axis_motion_pkg::CTRL_ARM_ABS]) begin
                    n.bp_arm = 1'b1;
                    n.bpos = (s.per == 24'h0) ? s.bval : 32'(per_start) + s.bval;
                end else if (wv[axis_motion_pkg::CTRL_ARM_REL]) begin
                    n.bp_arm = 1'b1;
                    n.bpos = s.pos + s.bval;
                end
            end
            else if (hit(s.aw_a, axis_motion_pkg::OFF_ACCEL)) begin
                if (s.st == axis_motion_pkg::M_IDLE || s.st == axis_motion_pkg::M_KILLED)
                    n.accel = sat(wv, axis_motion_pkg::ACC_MIN, ACC_MAX)
                        [23:0];
            end
            else if (hit(s.aw_a, axis_motion_pkg::OFF_FACTOR))
                n.fact = sat(wv, axis_motion_pkg::FACT_MIN, axis_motion_pkg::FACT_MAX)
                    [3:0];
            else if (hit(s.aw_a, axis_motion_pkg::OFF_PERIOD))
                n.per = sat(wv, axis_motion_pkg::PER_MIN, axis_motion_pkg::PER_MAX)
                    [23:0];
            else if (hit(s.aw_a, axis_motion_pkg::OFF_VMAX)) n.vmax = wv;
            else if (hit(s.aw_a, axis_motion_pkg::OFF_MOVE_TGT)) n.mtgt = wv;
            else if (hit(s.aw_a, axis_motion_pkg::OFF_POS_TGT)) n.ptgt = wv;
            else if (hit(s.aw_a, axis_motion_pkg::OFF_DEADBAND)) n.dband = wv;
            else if (hit(s.aw_a, axis_motion_pkg::OFF_BRK_VAL)) n.bval = wv;
            else if (hit(s.aw_a, axis_motion_pkg::OFF_TRIG) && s.tcnt != TFULL) begin
                n.tb[s.tcnt[CW-1:0]] = wv;
                n.tcnt = s.tcnt + 1'b1;
            end
            else if (hit(s.aw_a, axis_motion_pkg::OFF_STATUS)
                     && s.ws[0] && s.wd[axis_motion_pkg::STS_HIT])
                n.bp_hit = 1'b0;
        end
        if (TRIG_IN && s.tcnt != '0) n.trel = 1'b1;
        // A released entry runs only from rest; a same-cycle push is written before the pop.
        if (s.trel && s.st == axis_motion_pkg::M_IDLE && !go) begin
            go = 1'b1;
            go_tgt = s.tb[0];
            n.mtgt = s.tb[0];
            for (int i = 0; i < TRIG_DEPTH - 1; i++) n.tb[i] = n.tb[i + 1];
            n.tcnt = n.tcnt - 1'b1;
            n.trel = 1'b0;
        end
        if (go) begin
            n.st = axis_motion_pkg::M_RAMP;
            n.dir = $signed(go_tgt) < $signed(s.pos);
            n.vel = 32'h0;
            n.rdist = 32'h0;
        end
        else if (tk && is_moving(s.st)) begin
            left = s.dir ? $signed(s.pos - s.mtgt) : $signed(s.mtgt - s.pos);
            if (left <= 32'sd0) begin
                n.st = axis_motion_pkg::M_IDLE;
                n.pos = s.mtgt;
                n.frac = 16'h0;
                n.vel = 32'h0;
            end else begin
                // Braking starts when what is left is at or below the ramp-up distance.
                if (s.st == axis_motion_pkg::M_RAMP) begin
                    v = s.vel + sh.eff;
                    if (v >= s.vmax) begin
                        v = s.vmax;
                        n.st = axis_motion_pkg::M_CRUISE;
                    end
                    n.rdist = s.rdist + {16'h0, s.vel[31:16]};
                end else if (s.st == axis_motion_pkg::M_BRAKE) begin
                    v = (s.vel > sh.eff + axis_motion_pkg::VEL_MIN)
                        ? s.vel - sh.eff : axis_motion_pkg::VEL_MIN;
                end
                if ($signed(left) <= $signed(s.rdist) && s.st != axis_motion_pkg::M_BRAKE)
                    n.st = axis_motion_pkg::M_BRAKE;
                n.vel = v;
                np = s.dir ? {s.pos, s.frac} - {16'h0, v} : {s.pos, s.frac} + {16'h0, v};
                n.pos = np[47:16];
                n.frac = np[15:0];
                // One step pulse per sample; rates above one count per sample undercount.
                if (!IS_SERVO && np[47:16] != s.pos) begin
                    n.step = 1'b1;
                    n.cw = !s.dir;
                    n.ccw = s.dir;
                end
                if (s.bp_arm && (s.dir ? $signed(np[47:16]) <= $signed(s.bpos)
                                       : $signed(np[47:16]) >= $signed(s.bpos))) begin
                    n.brk = 1'b1;
                    n.bp_hit = 1'b1;
                    n.bp_arm = 1'b0;
                end
            end
        end
        n.pres = (absd(s.pos, s.ptgt) <= s.dband) ? 32'h0 : absd(s.pos, s.ptgt);
        if (wr_kill) begin
            n.st = axis_motion_pkg::M_KILLED;
            n.vel = 32'h0;
            n.rdist = 32'h0;
            n.tcnt = '0;
            n.trel = 1'b0;
            n.step = 1'b0;
            n.cw = 1'b0;
            n.ccw = 1'b0;
        end
        n.mcmd = (!IS_SERVO || n.st == axis_motion_pkg::M_KILLED) ? 16'h0
               : (n.dir ? 16'(-n.vel[31:16]) : n.vel[31:16]);
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            s <= '0;
            s.st <= axis_motion_pkg::M_IDLE;
            s.accel <= ACC_DEF[23:0];
            s.fact <= axis_motion_pkg::FACT_DEF[3:0];
            s.per <= axis_motion_pkg::PER_DEF[23:0];
            s.vmax <= axis_motion_pkg::VMAX_DEF;
        end else begin
            s <= n;
        end
    end

    sequence kill_req;
        wr_kill;
    endsequence
    sequence killed_now;
        INHIBIT_OUT && !MOTOR_EN && MOTOR_CMD == 16'h0 && s.vel == 32'h0;
    endsequence

    kill_halt_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        kill_req |=> killed_now)
        else $error("kill did not halt the axis at once");
    kill_inhibit_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        kill_req ##1 s.st == axis_motion_pkg::M_KILLED |-> INHIBIT_OUT[*2])
        else $error("inhibit not held after kill");
    kill_flush_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        kill_req |=> s.tcnt == '0 && !s.trel)
        else $error("trigger buffer not flushed on kill");
    kill_step_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        INHIBIT_OUT |-> !STEP_OUT && !CW_OUT && !CCW_OUT)
        else $error("step pulses while killed");
    accel_range_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        {8'h00, s.accel} >= axis_motion_pkg::ACC_MIN && {8'h00, s.accel} <= ACC_MAX)
        else $error("acceleration out of range");
    factor_range_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        s.fact >= 4'h1 && s.fact <= 4'hA)
        else $error("boost factor out of range");
    accel_moving_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        do_wr && hit(s.aw_a, axis_motion_pkg::OFF_ACCEL) && is_moving(s.st)
        |=> $stable(s.accel))
        else $error("acceleration loaded while moving");
    period_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !(do_wr && hit(s.aw_a, axis_motion_pkg::OFF_PERIOD)) |=> $stable(s.per))
        else $error("repeat period changed without a load");
    inpos_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ##1 (s.pres == 32'h0) == (absd($past(s.pos), $past(s.ptgt)) <= $past(s.dband)))
        else $error("in-position result wrong");
    abs_arm_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        do_wr && hit(s.aw_a, axis_motion_pkg::OFF_CTRL) && s.ws[0] && s.per != 24'h0
        && s.wd[axis_motion_pkg::CTRL_ARM_ABS]
        |=> $signed(s.bpos - $past(s.bval)) <= $signed($past(s.pos))
            && $signed($past(s.pos)) < $signed(s.bpos - $past(s.bval) + {8'h00, s.per}))
        else $error("absolute breakpoint not in current period");
endmodule : axis_motion_param_unit
`default_nettype wire

/* verif/amp_model.sv */
`timescale 1ns/100ps
`default_nettype none
module amp_model (
    input wire logic MOTOR_EN,
    input wire logic INHIBIT_OUT,
    input wire logic go,
    output logic TRIG_IN
);
    // The amplifier only passes a trigger while it is enabled and not inhibited.
    assign TRIG_IN = go & MOTOR_EN & ~INHIBIT_OUT;
endmodule : amp_model
`default_nettype wire

/* verif/axis_motion_param_unit_test.sv */
`timescale 1ns/100ps
`default_nettype none
module axis_motion_param_unit_test;
    logic REF_CLK = 0, RSTN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0;
    logic RREADY = 0, go = 0, poll = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID, TRIG_IN;
    logic MOTOR_EN, INHIBIT_OUT, STEP_OUT, DIR_OUT, CW_OUT, CCW_OUT, BREAK_OUT;
    logic [5:0] AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, RDATA, r;
    logic [3:0] WSTRB = 4'hF;
    logic [1:0] BRESP, RRESP;
    logic [15:0] MOTOR_CMD;
    logic [33:0] q[$], v;
    logic [5:0] ta[6] = '{6'h04, 6'h04, 6'h08, 6'h08, 6'h0C, 6'h0C};
    logic [31:0] tv[6] = '{32'h0, 32'hFFFF_FFFF, 32'h0, 32'hB, 32'hFFFF_FFFF, 32'h0};
    logic [31:0] te[6] = '{32'h1, 32'hFF_FFFF, 32'h1, 32'hA, 32'hFF_FFFF, 32'h0};
    int num_errors = 0, n_checks = 0;
    always #4 REF_CLK = ~REF_CLK;
    axis_motion_param_unit #(.SAMPLE_CYC(4)) i_axis_motion_param_unit (
        .REF_CLK(REF_CLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .TRIG_IN(TRIG_IN), .MOTOR_EN(MOTOR_EN),
        .MOTOR_CMD(MOTOR_CMD), .INHIBIT_OUT(INHIBIT_OUT), .STEP_OUT(STEP_OUT),
        .DIR_OUT(DIR_OUT), .CW_OUT(CW_OUT), .CCW_OUT(CCW_OUT), .BREAK_OUT(BREAK_OUT)
    );
    amp_model i_amp_model (
        .MOTOR_EN(MOTOR_EN), .INHIBIT_OUT(INHIBIT_OUT), .go(go), .TRIG_IN(TRIG_IN)
    );
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic hang(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            print_verdict;
        end
    endtask : hang
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge REF_CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        q.push_back({axis_motion_pkg::RESP_OKAY, 32'h0});
        do begin
            @(posedge REF_CLK);
            n++;
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID && n < 300);
        BREADY <= 1'b0;
        hang(n, 300);
    endtask : wr
    // Polled reads skip the queue so status loops do not flood it.
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input bit p = 0);
        int n = 0;
        @(posedge REF_CLK);
        poll = p;
        if (!p) q.push_back({axis_motion_pkg::RESP_OKAY, e});
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID && n < 300);
        v = {RRESP, RDATA};
        RREADY <= 1'b0;
        hang(n, 300);
    endtask : rd
    always @(posedge REF_CLK) if (RVALID && RREADY && !poll) chk({RRESP, RDATA}, q.pop_front());
    always @(posedge REF_CLK) if (BVALID && BREADY) chk({BRESP, 32'h0}, q.pop_front());
    task automatic move(input logic [31:0] t, input logic [31:0] acc);
        int n = 0;
        wr(axis_motion_pkg::OFF_MOVE_TGT, t);
        wr(axis_motion_pkg::OFF_CTRL, 32'h1);
        wr(axis_motion_pkg::OFF_ACCEL, 32'h5);
        do begin
            rd(axis_motion_pkg::OFF_STATUS, 0, 1);
            n++;
        end while (v[0] !== 1'b0 && n < 1000);
        hang(n, 1000);
        rd(axis_motion_pkg::OFF_ACCEL, acc);
        rd(axis_motion_pkg::OFF_POSITION, t);
        chk(DIR_OUT, t[31]);
    endtask : move
    task automatic brk(input logic [31:0] p, input logic [31:0] b, input logic [31:0] e);
        wr(axis_motion_pkg::OFF_PERIOD, p);
        wr(axis_motion_pkg::OFF_BRK_VAL, b);
        wr(axis_motion_pkg::OFF_CTRL, 32'h4);
        rd(axis_motion_pkg::OFF_BRK_POS, e);
    endtask : brk
    initial begin
        void'($urandom(32'h9105));
        repeat (2) @(posedge REF_CLK);
        RSTN <= 1'b1;
        rd(axis_motion_pkg::OFF_ACCEL, axis_motion_pkg::SERVO_ACC_DEF);
        rd(axis_motion_pkg::OFF_FACTOR, axis_motion_pkg::FACT_DEF);
        rd(axis_motion_pkg::OFF_PERIOD, axis_motion_pkg::PER_DEF);
        rd(6'h38, 0, 1);
        chk(v[33:32], axis_motion_pkg::RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            wr(ta[i], tv[i]);
            rd(ta[i], te[i]);
        end
        // Random accelerations stay high enough that each move ends in time.
        r = 32'h8_0000 + $urandom % 32'hF8_0000;
        wr(axis_motion_pkg::OFF_ACCEL, r);
        wr(axis_motion_pkg::OFF_VMAX, 32'h100_0000);
        move(32'd2530, r);
        wr(axis_motion_pkg::OFF_POS_TGT, 32'd2500);
        wr(axis_motion_pkg::OFF_DEADBAND, 32'd30);
        rd(axis_motion_pkg::OFF_INPOS, 0);
        wr(axis_motion_pkg::OFF_DEADBAND, 32'd29);
        rd(axis_motion_pkg::OFF_INPOS, 32'd30);
        brk(32'd2000, 32'd1000, 32'd3000);
        wr(axis_motion_pkg::OFF_CTRL, 32'h8);
        rd(axis_motion_pkg::OFF_BRK_POS, 32'd3530);
        move(-32'sd25000, r);
        brk(32'd10000, 32'd2500, -32'sd27500);
        wr(axis_motion_pkg::OFF_TRIG, 32'h100);
        wr(axis_motion_pkg::OFF_TRIG, 32'h200);
        rd(axis_motion_pkg::OFF_TRIG, 32'd2);
        wr(axis_motion_pkg::OFF_MOVE_TGT, 32'h0);
        wr(axis_motion_pkg::OFF_CTRL, 32'h1);
        wr(axis_motion_pkg::OFF_CTRL, 32'h2);
        repeat (2) @(posedge REF_CLK);
        chk({MOTOR_EN, INHIBIT_OUT, MOTOR_CMD}, 34'h1_0000);
        rd(axis_motion_pkg::OFF_STATUS, 0, 1);
        chk(v[1:0], 2'b10);
        go <= 1'b1;
        rd(axis_motion_pkg::OFF_TRIG, 32'd0);
        print_verdict;
    end
endmodule : axis_motion_param_unit_test
`default_nettype wire
